// >>> dv/device_capability_registers_tb_top.sv
// Self-checking bench for the capability register bank read over APB
`timescale 1ns/1ns
module device_capability_registers_tb_top;
  // ==========================================================================
  // Part settings; instance b carries the complement of instance a
  // ==========================================================================
  localparam logic [7:0] PN_A   = 8'hA7;
  localparam logic       ACC_A  = 1'b1;
  localparam logic [3:0] RAM_A  = 4'h9;
  localparam logic       CAN_A  = 1'b0;
  localparam logic       ENC_A  = 1'b1;
  localparam logic       CAP_A  = 1'b0;
  localparam logic       I2C_A  = 1'b1;
  localparam logic       SPI_A  = 1'b0;
  localparam logic [2:0] SER_A  = 3'h5;
  localparam logic [6:0] TRIP_A = 7'h55;
  localparam logic [6:0] PWM_A  = 7'h2B;
  localparam logic [11:0] W1    = capability_pkg::WORD_ONE_OFFSET[11:0];
  localparam logic [11:0] W2    = capability_pkg::WORD_TWO_OFFSET[11:0];
  localparam logic [11:0] W3    = capability_pkg::WORD_THREE_OFFSET[11:0];
  localparam logic [11:0] PID   = capability_pkg::PART_ID_OFFSET[11:0];

  typedef struct {logic [11:0] addr; logic wr; int idx; logic err;} row_s;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata_a, prdata_b;
  logic        pready_a, pready_b, pslverr_a, pslverr_b;
  logic [31:0] exp_a [0:4];
  logic [31:0] exp_b [0:4];
  row_s        rows  [0:17];
  int          num_errors, n_checks;

  // ==========================================================================
  // Two parts with opposite presence settings
  // ==========================================================================
  capability_regs #(.ADDR_WIDTH(12), .PART_NUMBER(PN_A), .ACCEL_PRESENT(ACC_A), .RAM_PRESENT(RAM_A),
    .CAN_PRESENT(CAN_A), .ENC_PRESENT(ENC_A), .CAP_PRESENT(CAP_A), .I2C_PRESENT(I2C_A), .SPI_PRESENT(SPI_A),
    .SERIAL_PRESENT(SER_A), .TRIP_PRESENT(TRIP_A), .PWM_PRESENT(PWM_A)) i_capability_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_a), .pready(pready_a), .pslverr(pslverr_a));
  capability_regs #(.ADDR_WIDTH(12), .PART_NUMBER(~PN_A), .ACCEL_PRESENT(~ACC_A), .RAM_PRESENT(~RAM_A),
    .CAN_PRESENT(~CAN_A), .ENC_PRESENT(~ENC_A), .CAP_PRESENT(~CAP_A), .I2C_PRESENT(~I2C_A),
    .SPI_PRESENT(~SPI_A), .SERIAL_PRESENT(~SER_A), .TRIP_PRESENT(~TRIP_A), .PWM_PRESENT(~PWM_A))
    i_capability_regs_inv (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_b), .pready(pready_b), .pslverr(pslverr_b));

  // ==========================================================================
  // Compare tasks and closing
  // ==========================================================================
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk32(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Write data: defined bits high, reserved bits as last read (zero)
  function automatic logic [31:0] wdata(input logic [11:0] a);
    case (a)
      W1:      wdata = 32'h3FC0_2078;
      W2:      wdata = 32'h0801_1117;
      W3:      wdata = 32'h000F_E07F;
      PID:     wdata = 32'h0000_00FF;
      default: wdata = 32'h0000_0000;
    endcase
  endfunction

  // One APB transfer; last releases the bus, otherwise the next setup follows at once
  task automatic xfer(input logic [11:0] a, input logic wr, input int idx, input logic err, input logic last);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wdata(a);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!(pready_a === 1'b1 && pready_b === 1'b1) && n < 16);
    chk1("pready", 1'b1, pready_a & pready_b);
    chk32("prdata a", exp_a[idx], prdata_a);
    chk32("prdata b", exp_b[idx], prdata_b);
    chk1("pslverr a", err, pslverr_a);
    chk1("pslverr b", err, pslverr_b);
    if (last)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rst_chk;
    @(negedge pclk);
    chk32("reset prdata", 32'h0, prdata_a | prdata_b);
    chk1("reset pslverr", 1'b0, pslverr_a | pslverr_b);
    chk1("reset pready", 1'b1, pready_a & pready_b);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    repeat (2000) @(posedge pclk);
    num_errors++;
    $display("wrong value watchdog expected done seen hang");
    results();
  end

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
    exp_a[0] = ({24'h0, PN_A} << 22) | ({31'h0, ACC_A} << 13) | ({28'h0, RAM_A} << 3);
    exp_a[1] = ({31'h0, CAN_A} << 27) | ({31'h0, ENC_A} << 16) | ({31'h0, CAP_A} << 12)
             | ({31'h0, I2C_A} << 8) | ({31'h0, SPI_A} << 4) | {29'h0, SER_A};
    exp_a[2] = ({25'h0, TRIP_A} << 13) | {25'h0, PWM_A};
    exp_a[3] = {24'h0, PN_A};
    exp_a[4] = 32'h0000_0000;
    exp_b[0] = exp_a[0] ^ 32'h3FC0_2078;
    exp_b[1] = exp_a[1] ^ 32'h0801_1117;
    exp_b[2] = exp_a[2] ^ 32'h000F_E07F;
    exp_b[3] = exp_a[3] ^ 32'h0000_00FF;
    exp_b[4] = 32'h0000_0000;
    rows[0]  = '{W1, 1'b0, 0, 1'b0};
    rows[1]  = '{W2, 1'b0, 1, 1'b0};
    rows[2]  = '{W3, 1'b0, 2, 1'b0};
    rows[3]  = '{PID, 1'b0, 3, 1'b0};
    rows[4]  = '{12'h010, 1'b0, 4, 1'b1};
    rows[5]  = '{W1, 1'b0, 0, 1'b0};
    rows[6]  = '{12'h002, 1'b0, 4, 1'b1};
    rows[7]  = '{12'hFFC, 1'b0, 4, 1'b1};
    rows[8]  = '{W1, 1'b1, 4, 1'b0};
    rows[9]  = '{W2, 1'b1, 4, 1'b0};
    rows[10] = '{W3, 1'b1, 4, 1'b0};
    rows[11] = '{PID, 1'b1, 4, 1'b0};
    rows[12] = '{12'h010, 1'b1, 4, 1'b1};
    rows[13] = '{W1, 1'b0, 0, 1'b0};
    rows[14] = '{W2, 1'b0, 1, 1'b0};
    rows[15] = '{W3, 1'b0, 2, 1'b0};
    rows[16] = '{PID, 1'b0, 3, 1'b0};
    rows[17] = '{12'h014, 1'b0, 4, 1'b1};
    repeat (10) @(posedge pclk);
    rst_chk();
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i])
      xfer(rows[i].addr, rows[i].wr, rows[i].idx, rows[i].err, (i % 2) == 1);
    $display("test table done");
    // Reset lands in the access phase of a read whose data is already loaded
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= W1;
    pwrite  <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    presetn <= 1'b0;
    rst_chk();
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(12'h010, 1'b0, 4, 1'b1, 1'b0);
    xfer(W2, 1'b0, 1, 1'b0, 1'b1);
    $display("test reset done");
    results();
  end
endmodule

// >>> src/capability_if.sv
// Carrier of the assembled capability words between builder and bus slave
`timescale 1ns/1ns
interface capability_if;
  logic [31:0] word_one;
  logic [31:0] word_two;
  logic [31:0] word_three;
  logic [31:0] part_id;

  modport producer
  (
    output word_one,
    output word_two,
    output word_three,
    output part_id
  );

  modport consumer
  (
    input  word_one,
    input  word_two,
    input  word_three,
    input  part_id
  );
endinterface

// >>> src/capability_pkg.sv
// Register map, field positions and masks of the capability register bank
package capability_pkg;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [31:0] WORD_ONE_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] WORD_TWO_OFFSET   = 32'h0000_0004;
  localparam logic [31:0] WORD_THREE_OFFSET = 32'h0000_0008;
  localparam logic [31:0] PART_ID_OFFSET    = 32'h0000_000C;

  // ==========================================================================
  // Capability word one fields
  // ==========================================================================
  localparam int PART_NUMBER_WIDTH = 8;
  localparam int PART_NUMBER_LSB   = 22;
  localparam int PART_NUMBER_MSB   = 29;
  localparam int ACCEL_BIT         = 13;
  localparam int LOCAL_RAM_COUNT   = 4;
  localparam int LOCAL_RAM_LSB     = 3;

  // ==========================================================================
  // Capability word two fields
  // ==========================================================================
  localparam int CAN_BIT           = 27;
  localparam int ENCODER_BIT       = 16;
  localparam int CAPTURE_BIT       = 12;
  localparam int I2C_BIT           = 8;
  localparam int SPI_BIT           = 4;
  localparam int SERIAL_PORT_COUNT = 3;
  localparam int SERIAL_PORT_LSB   = 0;

  // ==========================================================================
  // Capability word three fields
  // ==========================================================================
  localparam int TRIP_FILTER_COUNT = 7;
  localparam int TRIP_FILTER_LSB   = 13;
  localparam int MODULATOR_COUNT   = 7;
  localparam int MODULATOR_LSB     = 0;

  // ==========================================================================
  // Part identifier field and masks of defined bits
  // ==========================================================================
  localparam int          PART_ID_LSB      = 0;
  localparam logic [31:0] WORD_ONE_MASK    = 32'h3FC0_2078;
  localparam logic [31:0] WORD_TWO_MASK    = 32'h0801_1117;
  localparam logic [31:0] WORD_THREE_MASK  = 32'h000F_E07F;
  localparam logic [31:0] PART_ID_MASK     = 32'h0000_00FF;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

endpackage

// >>> src/capability_regs.sv
// APB slave presenting the read-only capability words and part identifier
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module capability_regs #(
  parameter int                                            ADDR_WIDTH    = 12,
  parameter logic [capability_pkg::PART_NUMBER_WIDTH-1:0] PART_NUMBER   = 8'h5A,
  parameter logic                                          ACCEL_PRESENT = 1'b1,
  parameter logic [capability_pkg::LOCAL_RAM_COUNT-1:0]   RAM_PRESENT   = 4'hF,
  parameter logic                                          CAN_PRESENT   = 1'b1,
  parameter logic                                          ENC_PRESENT   = 1'b1,
  parameter logic                                          CAP_PRESENT   = 1'b1,
  parameter logic                                          I2C_PRESENT   = 1'b1,
  parameter logic                                          SPI_PRESENT   = 1'b1,
  parameter logic [capability_pkg::SERIAL_PORT_COUNT-1:0] SERIAL_PRESENT = 3'h7,
  parameter logic [capability_pkg::TRIP_FILTER_COUNT-1:0] TRIP_PRESENT  = 7'h7F,
  parameter logic [capability_pkg::MODULATOR_COUNT-1:0]   PWM_PRESENT   = 7'h7F
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  generate
    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32)
    begin : g_bad_width
      $error("ADDR_WIDTH must lie between 4 and 32");
    end
  endgenerate

  // ==========================================================================
  // Address decode helpers
  // ==========================================================================
  function automatic logic hits(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] offset);
    hits = (a == offset[ADDR_WIDTH-1:0]);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
    is_mapped = hits(a, capability_pkg::WORD_ONE_OFFSET) || hits(a, capability_pkg::WORD_TWO_OFFSET) ||
                hits(a, capability_pkg::WORD_THREE_OFFSET) || hits(a, capability_pkg::PART_ID_OFFSET);
  endfunction

  // ==========================================================================
  // Fixed words
  // ==========================================================================
  capability_if words ();

  capability_words #(
    .PART_NUMBER    (PART_NUMBER),
    .ACCEL_PRESENT  (ACCEL_PRESENT),
    .RAM_PRESENT    (RAM_PRESENT),
    .CAN_PRESENT    (CAN_PRESENT),
    .ENC_PRESENT    (ENC_PRESENT),
    .CAP_PRESENT    (CAP_PRESENT),
    .I2C_PRESENT    (I2C_PRESENT),
    .SPI_PRESENT    (SPI_PRESENT),
    .SERIAL_PRESENT (SERIAL_PRESENT),
    .TRIP_PRESENT   (TRIP_PRESENT),
    .PWM_PRESENT    (PWM_PRESENT)
  ) u_words (
    .words (words.producer)
  );

  // ==========================================================================
  // Read data and error, captured in the setup cycle
  // ==========================================================================
  logic        setup_phase;
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;
  logic        pslverr_d;
  logic        pslverr_q;

  assign setup_phase = psel && !penable;

  always_comb
  begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_phase)
    begin
      // Writes are accepted but never stored: the words are fixed by the part
      pslverr_d = !is_mapped(paddr);
      prdata_d  = capability_pkg::ZERO_WORD;
      if (!pwrite)
      begin
        if (hits(paddr, capability_pkg::WORD_ONE_OFFSET))
        begin
          prdata_d = words.word_one;
        end
        else if (hits(paddr, capability_pkg::WORD_TWO_OFFSET))
        begin
          prdata_d = words.word_two;
        end
        else if (hits(paddr, capability_pkg::WORD_THREE_OFFSET))
        begin
          prdata_d = words.word_three;
        end
        else if (hits(paddr, capability_pkg::PART_ID_OFFSET))
        begin
          prdata_d = words.part_id;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= capability_pkg::ZERO_WORD;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign pready  = 1'b1;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;

  a_part_field: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_ONE_OFFSET) |->
      prdata[capability_pkg::PART_NUMBER_MSB:capability_pkg::PART_NUMBER_LSB] == PART_NUMBER)
    else $error("part number field wrong in word one");

  a_part_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::PART_ID_OFFSET) |->
      prdata == {24'h00_0000, PART_NUMBER})
    else $error("part identifier does not mirror part number");

  a_accel_bit: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_ONE_OFFSET) |-> prdata[capability_pkg::ACCEL_BIT] == ACCEL_PRESENT)
    else $error("accelerator presence bit wrong");

  a_ram_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_ONE_OFFSET) |->
      prdata[capability_pkg::LOCAL_RAM_LSB +: capability_pkg::LOCAL_RAM_COUNT] == RAM_PRESENT)
    else $error("local RAM presence bits wrong");

  a_can_bit: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_TWO_OFFSET) |-> prdata[capability_pkg::CAN_BIT] == CAN_PRESENT)
    else $error("CAN presence bit wrong");

  a_enc_cap_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_TWO_OFFSET) |->
      prdata[capability_pkg::ENCODER_BIT] == ENC_PRESENT && prdata[capability_pkg::CAPTURE_BIT] == CAP_PRESENT)
    else $error("encoder or capture presence bit wrong");

  a_i2c_spi_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_TWO_OFFSET) |->
      prdata[capability_pkg::I2C_BIT] == I2C_PRESENT && prdata[capability_pkg::SPI_BIT] == SPI_PRESENT)
    else $error("I2C or SPI presence bit wrong");

  a_serial_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_TWO_OFFSET) |->
      prdata[capability_pkg::SERIAL_PORT_LSB +: capability_pkg::SERIAL_PORT_COUNT] == SERIAL_PRESENT)
    else $error("serial port presence bits wrong");

  a_trip_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_THREE_OFFSET) |->
      prdata[capability_pkg::TRIP_FILTER_LSB +: capability_pkg::TRIP_FILTER_COUNT] == TRIP_PRESENT)
    else $error("trip filter presence bits wrong");

  a_pwm_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && hits(paddr, capability_pkg::WORD_THREE_OFFSET) |->
      prdata[capability_pkg::MODULATOR_LSB +: capability_pkg::MODULATOR_COUNT] == PWM_PRESENT)
    else $error("modulator presence bits wrong");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc |-> (hits(paddr, capability_pkg::WORD_ONE_OFFSET) ? (prdata & ~capability_pkg::WORD_ONE_MASK) == 32'h0 :
                hits(paddr, capability_pkg::WORD_TWO_OFFSET) ? (prdata & ~capability_pkg::WORD_TWO_MASK) == 32'h0 :
                hits(paddr, capability_pkg::WORD_THREE_OFFSET) ? (prdata & ~capability_pkg::WORD_THREE_MASK) == 32'h0 :
                (prdata & ~capability_pkg::PART_ID_MASK) == 32'h0))
    else $error("reserved bit reads nonzero");

  a_words_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite |-> prdata == capability_pkg::ZERO_WORD && pslverr == !is_mapped(paddr))
    else $error("write answered with data or wrong error");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready && (pslverr == !is_mapped(paddr)) && (pwrite || is_mapped(paddr) || prdata == 32'h0))
    else $error("wrong answer to access");

endmodule

// >>> src/capability_words.sv
// Assembles the fixed capability words from the part's presence settings
`timescale 1ns/1ns
module capability_words #(
  parameter logic [capability_pkg::PART_NUMBER_WIDTH-1:0] PART_NUMBER   = 8'h5A,
  parameter logic                                          ACCEL_PRESENT = 1'b1,
  parameter logic [capability_pkg::LOCAL_RAM_COUNT-1:0]   RAM_PRESENT   = 4'hF,
  parameter logic                                          CAN_PRESENT   = 1'b1,
  parameter logic                                          ENC_PRESENT   = 1'b1,
  parameter logic                                          CAP_PRESENT   = 1'b1,
  parameter logic                                          I2C_PRESENT   = 1'b1,
  parameter logic                                          SPI_PRESENT   = 1'b1,
  parameter logic [capability_pkg::SERIAL_PORT_COUNT-1:0] SERIAL_PRESENT = 3'h7,
  parameter logic [capability_pkg::TRIP_FILTER_COUNT-1:0] TRIP_PRESENT  = 7'h7F,
  parameter logic [capability_pkg::MODULATOR_COUNT-1:0]   PWM_PRESENT   = 7'h7F
) (
  capability_if.producer words
);

  // ==========================================================================
  // Word assembly; every position not set here stays zero
  // ==========================================================================
  always_comb
  begin
    words.word_one   = capability_pkg::ZERO_WORD;
    words.word_two   = capability_pkg::ZERO_WORD;
    words.word_three = capability_pkg::ZERO_WORD;
    words.part_id    = capability_pkg::ZERO_WORD;
    words.word_one[capability_pkg::PART_NUMBER_MSB:capability_pkg::PART_NUMBER_LSB] = PART_NUMBER;
    words.part_id[capability_pkg::PART_ID_LSB +: capability_pkg::PART_NUMBER_WIDTH] = PART_NUMBER;
    words.word_one[capability_pkg::ACCEL_BIT] = ACCEL_PRESENT;
    words.word_one[capability_pkg::LOCAL_RAM_LSB +: capability_pkg::LOCAL_RAM_COUNT] = RAM_PRESENT;
    words.word_two[capability_pkg::CAN_BIT] = CAN_PRESENT;
    words.word_two[capability_pkg::ENCODER_BIT] = ENC_PRESENT;
    words.word_two[capability_pkg::CAPTURE_BIT] = CAP_PRESENT;
    words.word_two[capability_pkg::I2C_BIT] = I2C_PRESENT;
    words.word_two[capability_pkg::SPI_BIT] = SPI_PRESENT;
    words.word_two[capability_pkg::SERIAL_PORT_LSB +: capability_pkg::SERIAL_PORT_COUNT] = SERIAL_PRESENT;
    words.word_three[capability_pkg::TRIP_FILTER_LSB +: capability_pkg::TRIP_FILTER_COUNT] = TRIP_PRESENT;
    words.word_three[capability_pkg::MODULATOR_LSB +: capability_pkg::MODULATOR_COUNT] = PWM_PRESENT;
  end

endmodule
